// ==== irq_sel_pkg.sv ====
package irq_sel_pkg;

  localparam int          FIELD_W      = 5;
  localparam int          FIELDS_PER   = 6;
  localparam int          MASK_LINES   = 12;
  localparam int          FIRST_MASKED = 4;
  localparam int          CPU_LINES    = 16;

  localparam logic [31:0] ADDR_SELECT_HIGH = 32'h019c_0000;
  localparam logic [31:0] ADDR_SELECT_LOW  = 32'h019c_0004;
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'h019c_0010;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'h019c_0014;
  localparam logic [31:0] SELECT_WMASK     = 32'h7fff_7fff;

  localparam logic [4:0] CODE_HOST_DSP   = 5'h00;
  localparam logic [4:0] CODE_TIMER0     = 5'h01;
  localparam logic [4:0] CODE_TIMER1     = 5'h02;
  localparam logic [4:0] CODE_SDRAM_REF  = 5'h03;
  localparam logic [4:0] CODE_PIN_IRQ_4  = 5'h04;
  localparam logic [4:0] CODE_PIN_IRQ_5  = 5'h05;
  localparam logic [4:0] CODE_PIN_IRQ_6  = 5'h06;
  localparam logic [4:0] CODE_PIN_IRQ_7  = 5'h07;
  localparam logic [4:0] CODE_DMA_DONE   = 5'h08;
  localparam logic [4:0] CODE_DEBUG_DMA  = 5'h09;
  localparam logic [4:0] CODE_DEBUG_RX   = 5'h0a;
  localparam logic [4:0] CODE_DEBUG_TX   = 5'h0b;
  localparam logic [4:0] CODE_SERIAL_TX  = 5'h0c;
  localparam logic [4:0] CODE_SERIAL_RX  = 5'h0d;
  localparam logic [4:0] CODE_GPIO_EV0   = 5'h10;
  localparam logic [4:0] CODE_TIMER2     = 5'h13;
  localparam logic [4:0] CODE_TWO_WIRE   = 5'h16;
  localparam logic [4:0] CODE_ETH_MGMT   = 5'h18;
  localparam logic [4:0] CODE_VIDEO1     = 5'h1a;
  localparam logic [4:0] CODE_VIDEO2     = 5'h1b;
  localparam logic [4:0] CODE_AUDIO_TX   = 5'h1c;
  localparam logic [4:0] CODE_AUDIO_RX   = 5'h1d;
  localparam logic [4:0] CODE_RESERVED   = 5'h0e;

  localparam logic [31:0] SELECT_LOW_RESET = {1'b0, CODE_DEBUG_DMA,
    CODE_DMA_DONE, CODE_PIN_IRQ_7, 1'b0, CODE_PIN_IRQ_6, CODE_PIN_IRQ_5,
    CODE_PIN_IRQ_4};
  localparam logic [31:0] SELECT_HIGH_RESET = {1'b0, CODE_TIMER1,
    CODE_TIMER0, CODE_HOST_DSP, 1'b0, CODE_DEBUG_TX, CODE_DEBUG_RX,
    CODE_SDRAM_REF};

  localparam logic [11:0] STATUS_RESET = 12'h000;
  localparam logic [11:0] MASK_RESET   = 12'h000;

  // On-chip sources, all on pclk; pin sources arrive separately
  typedef struct packed {
    logic host_dsp_irq;
    logic timer0_irq;
    logic timer1_irq;
    logic timer2_irq;
    logic sdram_refresh_irq;
    logic dma_done_irq;
    logic debug_dma_irq;
    logic debug_data_rx_irq;
    logic debug_data_tx_irq;
    logic serial_tx_irq;
    logic serial_rx_irq;
    logic gpio_event0_irq;
    logic two_wire_irq;
    logic ethernet_mgmt_irq;
    logic video_port1_irq;
    logic video_port2_irq;
    logic audio_tx_irq;
    logic audio_rx_irq;
  } irq_sources_t;

  // Fields skip bit 15 of each register
  function automatic int field_lsb(input int idx);
    field_lsb = (idx < 3) ? idx * FIELD_W : idx * FIELD_W + 1;
  endfunction

endpackage

// ==== cpu_interrupt_selector.sv ====
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module cpu_interrupt_selector
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [31:0]                paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       nmi_pin,
  input  wire logic [3:0]                 pin_irq,
  input  wire irq_sel_pkg::irq_sources_t  sources,
  output logic      [15:0]                cpu_irq,
  output logic                            irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0]  pin_meta_reg;
  logic [4:0]  pin_sync_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end
    else
    begin
      pin_meta_reg <= {pin_irq, nmi_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire logic       nmi_sync = pin_sync_reg[0];
  wire logic [3:0] pin_sync = pin_sync_reg[4:1];

  ////////////////////////////////////////////////////////////////////////////
  // Source vector indexed by selector code

  function automatic logic [31:0] build_sources(
    input irq_sel_pkg::irq_sources_t s,
    input logic [3:0]                p
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    v[irq_sel_pkg::CODE_HOST_DSP]  = s.host_dsp_irq;
    v[irq_sel_pkg::CODE_TIMER0]    = s.timer0_irq;
    v[irq_sel_pkg::CODE_TIMER1]    = s.timer1_irq;
    v[irq_sel_pkg::CODE_SDRAM_REF] = s.sdram_refresh_irq;
    v[irq_sel_pkg::CODE_PIN_IRQ_4] = p[0];
    v[irq_sel_pkg::CODE_PIN_IRQ_5] = p[1];
    v[irq_sel_pkg::CODE_PIN_IRQ_6] = p[2];
    v[irq_sel_pkg::CODE_PIN_IRQ_7] = p[3];
    v[irq_sel_pkg::CODE_DMA_DONE]  = s.dma_done_irq;
    v[irq_sel_pkg::CODE_DEBUG_DMA] = s.debug_dma_irq;
    v[irq_sel_pkg::CODE_DEBUG_RX]  = s.debug_data_rx_irq;
    v[irq_sel_pkg::CODE_DEBUG_TX]  = s.debug_data_tx_irq;
    v[irq_sel_pkg::CODE_SERIAL_TX] = s.serial_tx_irq;
    v[irq_sel_pkg::CODE_SERIAL_RX] = s.serial_rx_irq;
    v[irq_sel_pkg::CODE_GPIO_EV0]  = s.gpio_event0_irq;
    v[irq_sel_pkg::CODE_TIMER2]    = s.timer2_irq;
    v[irq_sel_pkg::CODE_TWO_WIRE]  = s.two_wire_irq;
    v[irq_sel_pkg::CODE_ETH_MGMT]  = s.ethernet_mgmt_irq;
    v[irq_sel_pkg::CODE_VIDEO1]    = s.video_port1_irq;
    v[irq_sel_pkg::CODE_VIDEO2]    = s.video_port2_irq;
    v[irq_sel_pkg::CODE_AUDIO_TX]  = s.audio_tx_irq;
    v[irq_sel_pkg::CODE_AUDIO_RX]  = s.audio_rx_irq;
    // Reserved codes stay low, so a bad field just silences the line
    build_sources = v;
  endfunction

  wire logic [31:0] src_vec = build_sources(sources, pin_sync);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [31:0] select_high_reg;
  logic [31:0] select_low_reg;
  logic [11:0] status_reg;
  logic [11:0] mask_reg;
  logic [31:0] prdata_reg;

  wire logic setup  = psel & ~penable;
  wire logic access = psel & penable;
  wire logic hit_high   = (paddr == irq_sel_pkg::ADDR_SELECT_HIGH);
  wire logic hit_low    = (paddr == irq_sel_pkg::ADDR_SELECT_LOW);
  wire logic hit_status = (paddr == irq_sel_pkg::ADDR_IRQ_STATUS);
  wire logic hit_mask   = (paddr == irq_sel_pkg::ADDR_IRQ_MASK);
  wire logic hit_any    = hit_high | hit_low | hit_status | hit_mask;
  wire logic wr_high    = access & pwrite & hit_high;
  wire logic wr_low     = access & pwrite & hit_low;
  wire logic wr_mask    = access & pwrite & hit_mask;
  wire logic rd_status  = access & ~pwrite & hit_status;

  wire logic [31:0] read_mux =
    hit_high   ? select_high_reg :
    hit_low    ? select_low_reg :
    hit_status ? {16'h0000, status_reg, 4'h0} :
    hit_mask   ? {16'h0000, mask_reg, 4'h0} :
                 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;
  assign prdata  = prdata_reg;

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_reg <= read_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector registers

  wire logic [31:0] select_wdata = pwdata & irq_sel_pkg::SELECT_WMASK;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_high_reg <= irq_sel_pkg::SELECT_HIGH_RESET;
      select_low_reg  <= irq_sel_pkg::SELECT_LOW_RESET;
    end
    else
    begin
      if (wr_high)
        select_high_reg <= select_wdata;
      if (wr_low)
        select_low_reg <= select_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing of the maskable lines

  wire logic [63:0] select_all = {select_high_reg, select_low_reg};
  wire logic [11:0] line_next;

  genvar gi;
  generate
    for (gi = 0; gi < irq_sel_pkg::MASK_LINES; gi = gi + 1)
    begin : g_line
      localparam int LSB = (gi / irq_sel_pkg::FIELDS_PER) * 32 +
        irq_sel_pkg::field_lsb(gi % irq_sel_pkg::FIELDS_PER);
      wire logic [4:0] code = select_all[LSB +: irq_sel_pkg::FIELD_W];
      assign line_next[gi] = src_vec[code];
    end
  endgenerate

  logic        reset_line_reg;
  logic        nmi_line_reg;
  logic [11:0] line_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_line_reg <= 1'b1;
      nmi_line_reg   <= 1'b0;
      line_reg       <= 12'h000;
    end
    else
    begin
      reset_line_reg <= 1'b0;
      nmi_line_reg   <= nmi_sync;
      line_reg       <= line_next;
    end
  end

  // Line 0 has top priority; the core resolves order by index
  assign cpu_irq = {line_reg, 2'b00, nmi_line_reg,
                    reset_line_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt output

  logic [11:0] line_prev_reg;
  wire logic [11:0] line_rise = line_reg & ~line_prev_reg;
  // Only bits that software actually saw are cleared; a new edge wins
  wire logic [11:0] status_clr =
    rd_status ? prdata_reg[15:4] : 12'h000;
  wire logic [11:0] status_next = (status_reg & ~status_clr) | line_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_prev_reg <= 12'h000;
      status_reg    <= irq_sel_pkg::STATUS_RESET;
      mask_reg      <= irq_sel_pkg::MASK_RESET;
    end
    else
    begin
      line_prev_reg <= line_reg;
      status_reg    <= status_next;
      if (wr_mask)
        mask_reg <= pwdata[15:4];
    end
  end

  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic first_cycle_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_cycle_reg <= 1'b1;
    else
      first_cycle_reg <= 1'b0;
  end

  a_fixed_lines_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_irq[3:2] == 2'b00 && (first_cycle_reg || !cpu_irq[0]))
    else $error("Reserved or reset line asserted outside reset");

  a_nmi_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    !first_cycle_reg |-> cpu_irq[1] == $past(nmi_sync))
    else $error("Non-maskable line did not follow its input");

  a_default_routing: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_cycle_reg |->
      select_low_reg == irq_sel_pkg::SELECT_LOW_RESET &&
      select_high_reg == irq_sel_pkg::SELECT_HIGH_RESET)
    else $error("Selector fields not at default routing after reset");

  a_low_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == irq_sel_pkg::ADDR_SELECT_LOW |=>
      select_low_reg == ($past(pwdata) & irq_sel_pkg::SELECT_WMASK) &&
      !select_low_reg[15] && !select_low_reg[31])
    else $error("Low selector write not stored as expected");

  a_high_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == irq_sel_pkg::ADDR_SELECT_HIGH |=>
      select_high_reg[30:26] == $past(pwdata[30:26]) &&
      select_high_reg[4:0] == $past(pwdata[4:0]))
    else $error("High selector write not stored as expected");

  a_timer_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_high_reg[25:21] == irq_sel_pkg::CODE_TIMER0 |=>
      cpu_irq[14] == $past(sources.timer0_irq))
    else $error("Line 14 does not follow timer 0");

  a_two_wire_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_low_reg[4:0] == irq_sel_pkg::CODE_TWO_WIRE |=>
      cpu_irq[4] == $past(sources.two_wire_irq))
    else $error("Line 4 does not follow the two-wire source");

  a_write_next_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == irq_sel_pkg::ADDR_SELECT_LOW &&
    pwdata[4:0] == irq_sel_pkg::CODE_DMA_DONE |=> ##1
      cpu_irq[4] == $past(sources.dma_done_irq))
    else $error("Field change did not act one cycle after the write");

  a_reserved_silent: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_high_reg[4:0] == irq_sel_pkg::CODE_RESERVED |=> !cpu_irq[10])
    else $error("Reserved code drove a CPU line");

  a_event_raises_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(cpu_irq[15]) && mask_reg[11] |=> irq)
    else $error("Unmasked event did not raise the interrupt");

  // A status bit may only go away through a read of the status register
  a_status_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_reg[11] && !rd_status |=> status_reg[11])
    else $error("Status bit dropped without a read");

  a_pin_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_low_reg[4:0] == irq_sel_pkg::CODE_PIN_IRQ_4 |=>
      cpu_irq[4] == $past(pin_sync[0]))
    else $error("Line 4 does not follow shared pin 4");

  a_dma_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_low_reg[25:21] == irq_sel_pkg::CODE_DMA_DONE |=>
      cpu_irq[8] == $past(sources.dma_done_irq))
    else $error("Line 8 does not follow the DMA done source");

  a_sdram_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    select_high_reg[4:0] == irq_sel_pkg::CODE_SDRAM_REF |=>
      cpu_irq[10] == $past(sources.sdram_refresh_irq))
    else $error("Line 10 does not follow the refresh source");

endmodule

// ==== cpu_core_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module cpu_core_model
(
  input  wire logic [15:0] cpu_irq,
  output logic      [4:0]  taken
);
  // Core takes the lowest-numbered pending line; bit 4 says one is pending
  always_comb
  begin
    taken = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (cpu_irq[i] === 1'b1) taken = {1'b1, 4'(i)};
  end
endmodule

// ==== cpu_interrupt_selector_bench.sv ====
`timescale 1ns/1ps
module cpu_interrupt_selector_bench;
  logic                      pclk;
  logic                      presetn;
  logic [31:0]               paddr;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      nmi_pin;
  logic [3:0]                pin_irq;
  logic [15:0]               cpu_irq;
  logic                      irq;
  logic [4:0]                taken;
  logic [31:0]               rd;
  logic                      err;
  logic [4:0]                fld [12];
  int                        bad_count;
  int                        samples_checked;
  irq_sel_pkg::irq_sources_t src;
  // Accepted codes; sbit is the struct bit, -1 for the pin sources
  logic [4:0] codes [22] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h13,
    5'h16, 5'h18, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  int         sbit  [22] = '{17, 16, 15, 13, -1, -1, -1, -1, 12, 11, 10, 9,
    8, 7, 6, 14, 5, 4, 3, 2, 1, 0};

  cpu_interrupt_selector dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
    .pin_irq(pin_irq), .sources(src), .cpu_irq(cpu_irq), .irq(irq));
  cpu_core_model core (.cpu_irq(cpu_irq), .taken(taken));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pack6(input int b);
    pack6 = {1'b0, fld[b+5], fld[b+4], fld[b+3], 1'b0, fld[b+2], fld[b+1],
      fld[b]};
  endfunction

  function automatic logic [15:0] expect_lines(input int k, input logic n);
    expect_lines = {14'h0000, n, 1'b0};
    for (int i = 0; i < 12; i++)
      if (fld[i] == codes[k]) expect_lines[i + 4] = 1'b1;
  endfunction

  function automatic logic [4:0] prio(input logic [15:0] v);
    prio = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (v[i]) prio = {1'b1, 4'(i)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Caller enters just after a rising edge; one idle cycle follows each access
  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic write_fields;
    apb(1'b1, irq_sel_pkg::ADDR_SELECT_LOW, pack6(0));
    apb(1'b1, irq_sel_pkg::ADDR_SELECT_HIGH, pack6(6));
  endtask

  task automatic drive(input int k, input logic v);
    if (sbit[k] < 0) pin_irq[codes[k] - 5'h04] <= v;
    else src[sbit[k]] <= v;
  endtask

  // Source is raised before any rewrite, so the new routing must pick it up
  task automatic probe(input int k, input logic rewrite);
    logic [15:0] e;
    drive(k, 1'b1);
    @(posedge pclk);
    if (rewrite) write_fields();
    repeat (5) @(posedge pclk);
    e = expect_lines(k, nmi_pin);
    chk(32'(cpu_irq), 32'(e));
    chk(32'(taken), 32'(prio(e)));
    drive(k, 1'b0);
    repeat (5) @(posedge pclk);
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    nmi_pin = 1'b0;
    pin_irq = 4'h0;
    src = '0;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(93));
    repeat (8) @(posedge pclk);
    chk(32'(cpu_irq), 32'h0000_0001);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(cpu_irq), 32'h0000_0000);
    chk(32'(pready), 32'h0000_0001);
    fld = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h03, 5'h0a, 5'h0b,
      5'h00, 5'h01, 5'h02};
    apb(1'b0, irq_sel_pkg::ADDR_SELECT_LOW, 32'h0000_0000);
    chk(rd, pack6(0));
    apb(1'b0, irq_sel_pkg::ADDR_SELECT_HIGH, 32'h0000_0000);
    chk(rd, pack6(6));
    // Lines 8 and 15 unmasked: a masked event must leave the output low
    apb(1'b1, irq_sel_pkg::ADDR_IRQ_MASK, 32'h0000_8100);
    probe(0, 1'b0);
    chk(32'(irq), 32'h0000_0000);
    probe(8, 1'b0);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b0, irq_sel_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_2100);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b0, irq_sel_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int k = 0; k < 22; k++)
      probe(k, 1'b0);
    apb(1'b1, irq_sel_pkg::ADDR_SELECT_LOW, pack6(0) | 32'h8000_8000);
    apb(1'b0, irq_sel_pkg::ADDR_SELECT_LOW, 32'h0000_0000);
    chk(rd, pack6(0));
    apb(1'b0, 32'h019c_0020, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // Every field on one source: all twelve lines must fire together
    foreach (fld[i]) fld[i] = codes[19];
    probe(19, 1'b1);
    foreach (fld[i]) fld[i] = codes[8];
    probe(8, 1'b1);
    foreach (fld[i]) fld[i] = codes[16];
    probe(16, 1'b1);
    for (int it = 0; it < 40; it++)
    begin
      foreach (fld[i]) fld[i] = codes[$urandom_range(21)];
      nmi_pin <= 1'($urandom);
      probe($urandom_range(21), 1'b1);
    end
    report_and_stop();
  end
endmodule
